// File: hw/prr_consts.svh
`ifndef PRR_CONSTS_SVH
`define PRR_CONSTS_SVH

// Register addresses on the serial register port
`define PRR_ADDR_PACE 8'h1A
`define PRR_ADDR_RMAG 8'h1B
`define PRR_ADDR_RPH 8'h1C
`define PRR_ADDR_ELECTRODE_DISCONNECT_STATUS 8'h1D

// Result word layout
`define PRR_WORD_W 32
`define PRR_DATA_W 24
`define PRR_HALF_W 16
`define PRR_ADDR_LSB 24
`define PRR_ADDR_W 8

// Pace field positions, channel n at base 8*n
`define PRR_PACE_STRIDE 8
`define PRR_PACE_DET_OFS 7
`define PRR_PACE_WID_OFS 4
`define PRR_PACE_HGT_OFS 0
`define PRR_PACE_WID_W 3
`define PRR_PACE_HGT_W 4
`define PRR_PACE_CH 3

`define PRR_RESET_VAL 24'h000000

// Phase reference codes
`define PRR_PH_QUARTER 24'h400000
`define PRR_PH_HALF 24'h800000
`define PRR_PH_3QUARTER 24'hC00000

// Frame rate and system clock rates in Hz
`define PRR_FRAME_RATE_HZ 128000
`define PRR_CLK_HZ 25000000

`endif

// File: hw/prr_pkg.sv
package prr_pkg;
   typedef enum logic [1:0] {
      PRR_ST_IDLE = 2'b00,
      PRR_ST_HIGH = 2'b01,
      PRR_ST_LOW = 2'b11
   } prr_state_e;

   typedef struct packed {
      logic detected;
      logic [2:0] width_code;
      logic [3:0] height_code;
   } prr_pace_ch_s;
endpackage

// File: hw/prr_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prr_fifo_if #(
   parameter int WIDTH = 16
);
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WIDTH-1:0] out_data;
   modport fill (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
   modport store (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// File: hw/prr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module prr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   prr_fifo_if.store port
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   always_comb begin
      push = port.in_valid && (cnt_q != (AW+1)'(DEPTH));
      pop = port.out_ready && (cnt_q != '0);
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      if (push) begin
         mem_d[wr_q] = port.in_data;
         wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
      mem_q <= mem_d;
   end

   assign port.in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign port.out_valid = (cnt_q != '0);
   assign port.out_data = mem_q[rd_q];

   a_fifo_no_overrun: assert property (@(posedge ref_clk) disable iff (rst)
      cnt_q == (AW+1)'(DEPTH) |=> cnt_q <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule
`default_nettype wire

// File: hw/prr_result_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "prr_consts.svh"
module prr_result_regs #(
   parameter bit FULL_FEATURE = 1'b1,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic frame_tick,
   input wire logic fast_rate,
   input wire logic [`PRR_PACE_CH-1:0] pace_trail,
   input wire logic [`PRR_PACE_CH*`PRR_PACE_WID_W-1:0] pace_width_code,
   input wire logic [`PRR_PACE_CH*`PRR_PACE_HGT_W-1:0] pace_height_code,
   input wire logic resp_valid,
   input wire logic [`PRR_DATA_W-1:0] resp_magnitude,
   input wire logic [`PRR_DATA_W-1:0] resp_phase,
   input wire logic [`PRR_DATA_W-1:0] electrode_disconnect_status,
   input wire logic rd_req,
   input wire logic wr_req,
   input wire logic [`PRR_ADDR_W-1:0] reg_addr,
   input wire logic [`PRR_WORD_W-1:0] reg_wdata,
   output logic rd_valid,
   output logic [`PRR_WORD_W-1:0] rd_word,
   output logic frm_valid,
   output logic [`PRR_HALF_W-1:0] frm_half,
   input wire logic frm_ready,
   output logic frm_stall
);
   // The frame tick and pace trail pins are asynchronous and pass two stages first; the width and height codes are sampled directly
   logic tick_s1_q, tick_s2_q, tick_s3_q;
   logic [`PRR_PACE_CH-1:0] trail_s1_q, trail_s2_q, trail_s3_q;
   logic [`PRR_DATA_W-1:0] pace_acc_q, pace_acc_d;
   logic [`PRR_DATA_W-1:0] pace_q, pace_d;
   logic [`PRR_DATA_W-1:0] rmag_q, rmag_d, rph_q, rph_d, electrode_disconnect_status_q, electrode_disconnect_status_d;
   logic rd_valid_q, rd_valid_d;
   logic [`PRR_WORD_W-1:0] rd_word_q, rd_word_d;
   logic frm_valid_q, frm_valid_d, frm_stall_q, frm_stall_d;
   logic [`PRR_HALF_W-1:0] frm_half_q, frm_half_d;
   logic tick_rise;
   logic [`PRR_PACE_CH-1:0] trail_rise;
   prr_pkg::prr_state_e st_q, st_d;
   logic [`PRR_WORD_W-1:0] word_q, word_d;
   logic fill_valid;
   logic [`PRR_HALF_W-1:0] fill_data;
   logic out_ready_d;

   prr_fifo_if #(.WIDTH(`PRR_HALF_W)) fif ();
   prr_fifo #(.WIDTH(`PRR_HALF_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .port(fif)
   );

   function automatic logic [`PRR_WORD_W-1:0] tag_word(input logic [`PRR_ADDR_W-1:0] a,
                                                       input logic [`PRR_DATA_W-1:0] d);
      tag_word = {a, d};
   endfunction

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tick_s1_q <= '0;
         trail_s1_q <= '0;
         trail_s2_q <= '0;
         trail_s3_q <= '0;
         tick_s2_q <= '0;
         tick_s3_q <= '0;
      end else begin
         tick_s1_q <= frame_tick;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
         trail_s1_q <= pace_trail;
         trail_s2_q <= trail_s1_q;
         trail_s3_q <= trail_s2_q;
      end
   end

   assign tick_rise = tick_s2_q && !tick_s3_q;
   assign trail_rise = trail_s2_q & ~trail_s3_q;

   // Result capture; the frame tick closes one frame and opens the next
   always_comb begin
      pace_acc_d = tick_rise ? `PRR_RESET_VAL : pace_acc_q;
      for (int c = 0; c < `PRR_PACE_CH; c++) begin
         if (trail_rise[c]) begin
            pace_acc_d[c*`PRR_PACE_STRIDE + `PRR_PACE_DET_OFS] = 1'b1;
            pace_acc_d[c*`PRR_PACE_STRIDE + `PRR_PACE_WID_OFS +: `PRR_PACE_WID_W] =
               pace_width_code[c*`PRR_PACE_WID_W +: `PRR_PACE_WID_W];
            pace_acc_d[c*`PRR_PACE_STRIDE + `PRR_PACE_HGT_OFS +: `PRR_PACE_HGT_W] =
               pace_height_code[c*`PRR_PACE_HGT_W +: `PRR_PACE_HGT_W];
         end
      end
      // Finished frame becomes visible; an edge in the tick cycle counts in the next frame
      pace_d = tick_rise ? pace_acc_q : pace_q;
      rmag_d = resp_valid ? resp_magnitude : rmag_q;
      rph_d = resp_valid ? resp_phase : rph_q;
      electrode_disconnect_status_d = tick_rise ? electrode_disconnect_status : electrode_disconnect_status_q;
      if (!FULL_FEATURE) begin
         pace_acc_d = `PRR_RESET_VAL;
         pace_d = `PRR_RESET_VAL;
         rmag_d = `PRR_RESET_VAL;
         rph_d = `PRR_RESET_VAL;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pace_acc_q <= `PRR_RESET_VAL;
         pace_q <= `PRR_RESET_VAL;
         rmag_q <= `PRR_RESET_VAL;
         rph_q <= `PRR_RESET_VAL;
         electrode_disconnect_status_q <= `PRR_RESET_VAL;
      end else begin
         pace_acc_q <= pace_acc_d;
         pace_q <= pace_d;
         rmag_q <= rmag_d;
         rph_q <= rph_d;
         electrode_disconnect_status_q <= electrode_disconnect_status_d;
      end
   end

   // Register reads return the full 32-bit word at any rate; writes are dropped
   always_comb begin
      rd_valid_d = rd_req && !wr_req;
      rd_word_d = '0;
      case (reg_addr)
         `PRR_ADDR_PACE: rd_word_d = tag_word(reg_addr, pace_q);
         `PRR_ADDR_RMAG: rd_word_d = tag_word(reg_addr, rmag_q);
         `PRR_ADDR_RPH: rd_word_d = tag_word(reg_addr, rph_q);
         `PRR_ADDR_ELECTRODE_DISCONNECT_STATUS: rd_word_d = tag_word(reg_addr, electrode_disconnect_status_q);
         default: rd_word_d = tag_word(reg_addr, `PRR_RESET_VAL);
      endcase
      if (!rd_valid_d) begin
         rd_word_d = rd_word_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_valid_q <= 1'b0;
         rd_word_q <= '0;
      end else begin
         rd_valid_q <= rd_valid_d;
         rd_word_q <= rd_word_d;
      end
   end

   // Fast-rate framing: each frame whose tick finds the framer idle splits the pace and magnitude words into halves
   always_comb begin
      st_d = st_q;
      word_d = word_q;
      fill_valid = 1'b0;
      fill_data = '0;
      case (st_q)
         prr_pkg::PRR_ST_IDLE: begin
            if (tick_rise && fast_rate && FULL_FEATURE) begin
               word_d = tag_word(`PRR_ADDR_PACE, pace_acc_q);
               st_d = prr_pkg::PRR_ST_HIGH;
            end
         end
         prr_pkg::PRR_ST_HIGH: begin
            fill_valid = 1'b1;
            fill_data = word_q[`PRR_WORD_W-1 -: `PRR_HALF_W];
            if (fif.in_ready) begin
               st_d = prr_pkg::PRR_ST_LOW;
            end
         end
         prr_pkg::PRR_ST_LOW: begin
            fill_valid = 1'b1;
            fill_data = word_q[`PRR_HALF_W-1:0];
            if (fif.in_ready) begin
               if (word_q[`PRR_WORD_W-1 -: `PRR_ADDR_W] == `PRR_ADDR_PACE) begin
                  word_d = tag_word(`PRR_ADDR_RMAG, rmag_q);
                  st_d = prr_pkg::PRR_ST_HIGH;
               end else begin
                  st_d = prr_pkg::PRR_ST_IDLE;
               end
            end
         end
         default: st_d = prr_pkg::PRR_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= prr_pkg::PRR_ST_IDLE;
         word_q <= '0;
      end else begin
         st_q <= st_d;
         word_q <= word_d;
      end
   end

   assign fif.in_valid = fill_valid;
   assign fif.in_data = fill_data;
   // Registered outputs, but the pop uses this cycle's frm_ready; skid avoided by popping only
   // when no half is held or the held half is taken in this cycle
   assign out_ready_d = fif.out_valid && (!frm_valid_q || frm_ready);
   assign fif.out_ready = out_ready_d;

   always_comb begin
      frm_valid_d = frm_valid_q;
      frm_half_d = frm_half_q;
      if (out_ready_d) begin
         frm_valid_d = 1'b1;
         frm_half_d = fif.out_data;
      end else if (frm_ready) begin
         frm_valid_d = 1'b0;
      end
      frm_stall_d = fill_valid && !fif.in_ready;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         frm_valid_q <= 1'b0;
         frm_half_q <= '0;
         frm_stall_q <= 1'b0;
      end else begin
         frm_valid_q <= frm_valid_d;
         frm_half_q <= frm_half_d;
         frm_stall_q <= frm_stall_d;
      end
   end

   assign rd_valid = rd_valid_q;
   assign rd_word = rd_word_q;
   assign frm_valid = frm_valid_q;
   assign frm_half = frm_half_q;
   assign frm_stall = frm_stall_q;

   a_write_no_effect: assert property (@(posedge ref_clk) disable iff (rst)
      wr_req && !resp_valid && !tick_rise |=> $stable(rmag_q) && $stable(pace_q))
      else $error("write altered a result");
   a_pace_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
      trail_rise[0] && !tick_rise && FULL_FEATURE |=> pace_acc_q[`PRR_PACE_DET_OFS])
      else $error("pace flag not set");
   a_width_code_cap: assert property (@(posedge ref_clk) disable iff (rst)
      trail_rise[1] && !tick_rise && FULL_FEATURE |=>
      pace_acc_q[`PRR_PACE_STRIDE + `PRR_PACE_WID_OFS +: `PRR_PACE_WID_W]
      == $past(pace_width_code[`PRR_PACE_WID_W +: `PRR_PACE_WID_W]))
      else $error("width code wrong");
   a_height_code_cap: assert property (@(posedge ref_clk) disable iff (rst)
      trail_rise[2] && !tick_rise && FULL_FEATURE |=>
      pace_acc_q[2*`PRR_PACE_STRIDE +: `PRR_PACE_HGT_W]
      == $past(pace_height_code[2*`PRR_PACE_HGT_W +: `PRR_PACE_HGT_W]))
      else $error("height code wrong");
   a_read_full_word: assert property (@(posedge ref_clk) disable iff (rst)
      rd_req && !wr_req && reg_addr == `PRR_ADDR_RMAG |=>
      rd_valid && rd_word == {`PRR_ADDR_RMAG, $past(rmag_q)})
      else $error("read word wrong");
   a_phase_capture: assert property (@(posedge ref_clk) disable iff (rst)
      resp_valid && FULL_FEATURE |=> rph_q == $past(resp_phase))
      else $error("phase not captured");
   a_reduced_silent: assert property (@(posedge ref_clk) disable iff (rst)
      !FULL_FEATURE |-> pace_q == '0 && rmag_q == '0 && rph_q == '0)
      else $error("reduced variant shows results");
   a_half_order: assert property (@(posedge ref_clk) disable iff (rst)
      st_q == prr_pkg::PRR_ST_HIGH && fif.in_ready |=> st_q == prr_pkg::PRR_ST_LOW
      && fill_data == $past(word_q[`PRR_HALF_W-1:0]))
      else $error("halves out of order");
   a_detail_addr: assert property (@(posedge ref_clk) disable iff (rst)
      rd_req && !wr_req && reg_addr == `PRR_ADDR_PACE |=> rd_word[`PRR_DATA_W-1:0]
      == $past(pace_q))
      else $error("pace read wrong");
   a_frame_latch: assert property (@(posedge ref_clk) disable iff (rst)
      tick_rise && FULL_FEATURE |=> pace_q == $past(pace_acc_q))
      else $error("pace word not latched at frame edge");
   a_frame_clear: assert property (@(posedge ref_clk) disable iff (rst)
      tick_rise && trail_rise == '0 |=> pace_acc_q == `PRR_RESET_VAL)
      else $error("pace flags not cleared for new frame");
   a_mag_capture: assert property (@(posedge ref_clk) disable iff (rst)
      resp_valid && FULL_FEATURE |=> rmag_q == $past(resp_magnitude))
      else $error("magnitude not captured");
   a_no_spurious_read: assert property (@(posedge ref_clk) disable iff (rst)
      (!rd_req || wr_req) |=> !rd_valid)
      else $error("answer without a read");
   a_read_word_held: assert property (@(posedge ref_clk) disable iff (rst)
      !rd_valid |-> $stable(rd_word))
      else $error("read word changed without a read");
   a_reset_clean: assert property (@(posedge ref_clk) disable iff (rst)
      $past(rst) |-> !rd_valid && rd_word == '0 && !frm_valid && !frm_stall && pace_q == '0)
      else $error("state not clear after reset");
   a_high_first: assert property (@(posedge ref_clk) disable iff (rst)
      st_q == prr_pkg::PRR_ST_IDLE && tick_rise && fast_rate && FULL_FEATURE |=>
      fill_data == {`PRR_ADDR_PACE, $past(pace_acc_q[`PRR_DATA_W-1 -: `PRR_ADDR_W])})
      else $error("frame does not open with pace high half");
   a_half_held: assert property (@(posedge ref_clk) disable iff (rst)
      frm_valid && !frm_ready |=> frm_valid && $stable(frm_half))
      else $error("half dropped before it was taken");
   a_stall_flag: assert property (@(posedge ref_clk) disable iff (rst)
      fill_valid && !fif.in_ready |=> frm_stall)
      else $error("stall not flagged while buffer full");
endmodule
`default_nettype wire

// File: test/prr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module prr_host_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [1:0] stall_mode,
   input wire logic frm_valid,
   output logic frm_ready,
   output logic taken
);
   logic [7:0] lfsr_q;
   // Halves are taken one per agreed cycle, in the order they arrive
   assign taken = frm_valid && frm_ready;
   // Mode 0 always ready, 1 random stalls, 2 ready held low to fill the buffer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lfsr_q <= 8'h5A;
         frm_ready <= 1'b0;
      end else begin
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
         frm_ready <= (stall_mode == 2'h0) || (stall_mode == 2'h1 && lfsr_q[0]);
      end
   end
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "prr_consts.svh"
module testbench;
   logic ref_clk = 1'b0;
   logic rst, frame_tick, fast_rate, resp_valid, rd_req, wr_req, frm_ready, taken;
   logic [2:0] pace_trail;
   logic [8:0] pace_width_code;
   logic [11:0] pace_height_code;
   logic [23:0] resp_magnitude, resp_phase, electrode_disconnect_status;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, rd_word, rd_word_l, w0, w1;
   logic rd_valid, frm_valid, frm_stall, frm_valid_l;
   logic [15:0] frm_half;
   logic [1:0] stall_mode;
   logic [23:0] pexp, mag_e, ph_e, electrode_disconnect_status_e;
   logic [23:0] corners [4] = '{`PRR_PH_QUARTER, `PRR_PH_HALF, `PRR_PH_3QUARTER, 24'hFFFFFF};
   logic [7:0] addrs [6] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h20, 8'h00};
   logic [15:0] rxq [$];
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   int k;
   always #20 ref_clk = ~ref_clk;
   prr_result_regs #(.FULL_FEATURE(1'b1), .FIFO_DEPTH(4)) dut (.ref_clk(ref_clk), .rst(rst),
      .frame_tick(frame_tick), .fast_rate(fast_rate), .pace_trail(pace_trail),
      .pace_width_code(pace_width_code), .pace_height_code(pace_height_code),
      .resp_valid(resp_valid), .resp_magnitude(resp_magnitude), .resp_phase(resp_phase),
      .electrode_disconnect_status(electrode_disconnect_status), .rd_req(rd_req),
      .wr_req(wr_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_valid(rd_valid),
      .rd_word(rd_word), .frm_valid(frm_valid), .frm_half(frm_half), .frm_ready(frm_ready),
      .frm_stall(frm_stall));
   // Reduced variant sees the same stimulus; its stream side is left idle
   prr_result_regs #(.FULL_FEATURE(1'b0), .FIFO_DEPTH(4)) dut_lite (.ref_clk(ref_clk),
      .rst(rst), .frame_tick(frame_tick), .fast_rate(fast_rate), .pace_trail(pace_trail),
      .pace_width_code(pace_width_code), .pace_height_code(pace_height_code),
      .resp_valid(resp_valid), .resp_magnitude(resp_magnitude), .resp_phase(resp_phase),
      .electrode_disconnect_status(electrode_disconnect_status), .rd_req(rd_req),
      .wr_req(wr_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_valid(),
      .rd_word(rd_word_l), .frm_valid(frm_valid_l), .frm_half(), .frm_ready(1'b1),
      .frm_stall());
   prr_host_model host (.ref_clk(ref_clk), .rst(rst), .stall_mode(stall_mode),
      .frm_valid(frm_valid), .frm_ready(frm_ready), .taken(taken));
   always @(posedge ref_clk) begin
      if (taken) begin
         rxq.push_back(frm_half);
      end
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [23:0] exp_pace(input logic [2:0] d, input logic [8:0] w,
                                            input logic [11:0] h);
      logic [23:0] r;
      for (int n = 0; n < 3; n++) begin
         // A channel without a pulse keeps its cleared fields
         r[8*n +: 8] = d[n] ? {1'b1, w[3*n +: 3], h[4*n +: 4]} : 8'h00;
      end
      return r;
   endfunction
   task automatic rd(input logic [7:0] a, input logic [23:0] e, input logic [31:0] m);
      logic [31:0] el;
      el = (a >= `PRR_ADDR_PACE && a <= `PRR_ADDR_RPH) ? {a, 24'h000000} : {a, e};
      @(posedge ref_clk);
      rd_req <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      rd_req <= 1'b0;
      @(negedge ref_clk);
      check({31'h0, rd_valid}, 32'h1);
      check(rd_word & m, {a, e} & m);
      check(rd_word_l & m, el & m);
   endtask
   task automatic frame();
      @(posedge ref_clk);
      frame_tick <= 1'b1;
      repeat (4) @(posedge ref_clk);
      frame_tick <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic pace_frame(input logic [2:0] det);
      @(posedge ref_clk);
      pace_width_code <= 9'($urandom);
      pace_height_code <= 12'($urandom);
      electrode_disconnect_status <= 24'($urandom);
      @(posedge ref_clk);
      pace_trail <= det;
      repeat (4) @(posedge ref_clk);
      pace_trail <= 3'h0;
      repeat (4) @(posedge ref_clk);
      pexp = exp_pace(det, pace_width_code, pace_height_code);
      electrode_disconnect_status_e = electrode_disconnect_status;
      frame();
   endtask
   initial begin
      void'($urandom(59));
      {rst, frame_tick, fast_rate, resp_valid, rd_req, wr_req} = 6'h20;
      {pace_trail, pace_width_code, pace_height_code, reg_addr, reg_wdata} = '0;
      {resp_magnitude, resp_phase, electrode_disconnect_status} = '0;
      stall_mode = 2'h0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (addrs[i]) rd(addrs[i], 24'h000000, 32'hFFFFFFFF);
      check({30'h0, frm_valid, frm_stall}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         mag_e = 24'($urandom);
         ph_e = corners[i];
         @(posedge ref_clk);
         {resp_valid, resp_magnitude, resp_phase} <= {1'b1, mag_e, ph_e};
         @(posedge ref_clk);
         resp_valid <= 1'b0;
         repeat (2) @(posedge ref_clk);
         rd(`PRR_ADDR_RMAG, mag_e, 32'hFFFFFFFF);
         rd(`PRR_ADDR_RPH, ph_e, 32'hFFFFFFFF);
      end
      for (int i = 0; i < 3; i++) begin
         pace_frame(i == 0 ? 3'h7 : 3'($urandom));
         rd(`PRR_ADDR_PACE, pexp, 32'hFFFFFFFF);
         rd(`PRR_ADDR_ELECTRODE_DISCONNECT_STATUS, electrode_disconnect_status_e, 32'hFFFFFFFF);
      end
      pace_frame(3'h0);
      rd(`PRR_ADDR_PACE, 24'h000000, 32'hFFFFFFFF);
      foreach (addrs[i]) begin
         @(posedge ref_clk);
         {wr_req, reg_addr, reg_wdata} <= {1'b1, addrs[i], 32'($urandom)};
         @(posedge ref_clk);
         wr_req <= 1'b0;
      end
      rd(`PRR_ADDR_PACE, 24'h000000, 32'hFFFFFFFF);
      rd(`PRR_ADDR_RMAG, mag_e, 32'hFFFFFFFF);
      rd(`PRR_ADDR_RPH, ph_e, 32'hFFFFFFFF);
      rd(`PRR_ADDR_ELECTRODE_DISCONNECT_STATUS, electrode_disconnect_status_e, 32'hFFFFFFFF);
      check(32'(rxq.size()), 32'h0);
      @(posedge ref_clk);
      fast_rate <= 1'b1;
      stall_mode <= 2'h1;
      pace_frame(3'h5);
      for (k = 0; k < 300 && rxq.size() < 4; k++) @(posedge ref_clk);
      w0 = {`PRR_ADDR_PACE, pexp};
      w1 = {`PRR_ADDR_RMAG, mag_e};
      check(32'(rxq.size()), 32'h4);
      check({rxq[0], rxq[1]}, w0);
      check({rxq[2], rxq[3]}, w1);
      check({31'h0, frm_valid_l}, 32'h0);
      rd(`PRR_ADDR_PACE, pexp, 32'hFFFFFFFF);
      rxq.delete();
      // Ready held low across two frames fills the shallow buffer and stalls the framer
      stall_mode <= 2'h2;
      frame();
      frame();
      @(negedge ref_clk);
      check({31'h0, frm_stall}, 32'h1);
      stall_mode <= 2'h0;
      repeat (100) @(posedge ref_clk);
      @(negedge ref_clk);
      check({31'h0, frm_valid}, 32'h0);
      check(32'(rxq.size()), 32'h8);
      check({16'h0, rxq[2]}, {16'h0, w1[31:16]});
      summarize();
   end
endmodule
`default_nettype wire
